// File: ptis_irq_src.sv
`timescale 1ns/10ps
`default_nettype none
`include "ptis_map.svh"
module ptis_irq_src
    import ptis_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Pins
    input wire logic ext_irq_line_zero_in,
    input wire logic ext_irq_line_one_in,
    input wire logic ext_irq_line_two_in,
    input wire logic [3:0] port_b_pins_in,
    // Core side
    input wire logic sleep_in,
    input wire logic timer_tick_in,
    output logic irq_high_out,
    output logic irq_low_out,
    output logic wake_out,
    output logic irq_out
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ctrl_primary_r; // Enables, flags, global enable
    logic [7:0] ctrl_second_r; // Polarities and priorities
    logic [7:0] ctrl_third_r; // Line one/two bits
    logic [7:0] timer_cfg_r; // Run and 8-bit mode
    logic [7:0] timer_count_low_r; // Count low byte
    logic [7:0] timer_count_high_r; // Count high byte
    logic [`PTIS_EV_BITS-1:0] irq_status_r; // Sticky events
    logic [`PTIS_EV_BITS-1:0] irq_mask_r; // Event mask
    logic [2:0] ext_meta_r; // First sync stage
    logic [2:0] ext_sync_r; // Second sync stage
    logic [2:0] ext_prev_r; // Previous synced level
    logic [3:0] port_meta_r; // Port first stage
    logic [3:0] port_sync_r; // Port second stage
    logic [3:0] port_prev_r; // Port previous level
    logic [2:0] ext_en_at_sleep_r; // Enables latched at sleep entry
    logic sleep_prev_r; // Sleep level last cycle
    ptis_bus_state_t bus_state_r; // Bus slave state

    // ****************************************
    // Event detection
    // ****************************************
    logic [2:0] ext_pol; // Polarity per line
    logic [2:0] ext_edge; // Qualified edge per line
    logic [2:0] ext_en; // Enable per line
    logic [2:0] ext_flag; // Flag per line
    logic port_change; // Any port bit changed
    logic tmr_wrap_low; // Low byte wraps
    logic tmr_ovf; // Overflow event
    logic wake_evt; // Wake event
    logic wr_acc; // Write accepted this cycle

    assign ext_pol = {ctrl_second_r[`PTIS_S_EDGE2], ctrl_second_r[`PTIS_S_EDGE1],
                      ctrl_second_r[`PTIS_S_EDGE0]};
    // Rising when polarity is one, falling otherwise
    assign ext_edge = (ext_pol & ext_sync_r & ~ext_prev_r)
                    | (~ext_pol & ~ext_sync_r & ext_prev_r);
    assign ext_en = {ctrl_third_r[`PTIS_T_EXT2_IE], ctrl_third_r[`PTIS_T_EXT1_IE],
                     ctrl_primary_r[`PTIS_P_EXT0_IE]};
    assign ext_flag = {ctrl_third_r[`PTIS_T_EXT2_IF], ctrl_third_r[`PTIS_T_EXT1_IF],
                       ctrl_primary_r[`PTIS_P_EXT0_IF]};
    assign port_change = |(port_sync_r ^ port_prev_r);
    assign tmr_wrap_low = timer_cfg_r[`PTIS_C_RUN] & timer_tick_in & (timer_count_low_r == 8'hFF);
    // Overflow point depends on counter width
    assign tmr_ovf = tmr_wrap_low & (timer_cfg_r[`PTIS_C_MODE8]
                   | (timer_count_high_r == 8'hFF));
    // Wake only by lines enabled before sleep began
    assign wake_evt = sleep_in & sleep_prev_r
                    & |(ext_edge & ext_en_at_sleep_r);
    assign wr_acc = (bus_state_r == PTIS_ACK) & avs_write_in;

    // Write data with byte lane zero
    function automatic logic [7:0] wbyte(input logic [7:0] old);
        wbyte = avs_byteenable_in[0] ? avs_writedata_in[7:0] : old;
    endfunction

    // Address match for accepted write
    function automatic logic hit(input logic [3:0] a);
        hit = wr_acc && (avs_address_in == a);
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ext_meta_r <= 3'h0;
            ext_sync_r <= 3'h0;
            ext_prev_r <= 3'h0;
            port_meta_r <= 4'h0;
            port_sync_r <= 4'h0;
            port_prev_r <= 4'h0;
        end else begin
            // Two stages, then previous for edge
            ext_meta_r <= {ext_irq_line_two_in, ext_irq_line_one_in, ext_irq_line_zero_in};
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
            port_meta_r <= port_b_pins_in;
            port_sync_r <= port_meta_r;
            port_prev_r <= port_sync_r;
        end
    end

    // ****************************************
    // Sleep tracking
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sleep_prev_r <= 1'b0;
            ext_en_at_sleep_r <= 3'h0;
        end else begin
            sleep_prev_r <= sleep_in;
            // Capture enables at sleep entry
            if (sleep_in && !sleep_prev_r) begin
                ext_en_at_sleep_r <= ext_en;
            end
        end
    end

    // ****************************************
    // Primary control: enables and flags
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_primary_r <= `PTIS_RST_PRIMARY;
        end else begin
            // Software write first, hardware sets win
            if (hit(`PTIS_ADDR_CTRL_PRIMARY)) begin
                ctrl_primary_r <= wbyte(ctrl_primary_r);
            end
            if (ext_edge[0]) begin
                ctrl_primary_r[`PTIS_P_EXT0_IF] <= 1'b1;
            end
            if (tmr_ovf) begin
                ctrl_primary_r[`PTIS_P_TMR_IF] <= 1'b1;
            end
            if (port_change) begin
                ctrl_primary_r[`PTIS_P_PORT_IF] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Second and third control
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_second_r <= `PTIS_RST_SECOND;
            ctrl_third_r <= `PTIS_RST_THIRD;
        end else begin
            if (hit(`PTIS_ADDR_CTRL_SECOND)) begin
                ctrl_second_r <= wbyte(ctrl_second_r);
            end
            if (hit(`PTIS_ADDR_CTRL_THIRD)) begin
                ctrl_third_r <= wbyte(ctrl_third_r);
            end
            // Flags set regardless of enables
            if (ext_edge[1]) begin
                ctrl_third_r[`PTIS_T_EXT1_IF] <= 1'b1;
            end
            if (ext_edge[2]) begin
                ctrl_third_r[`PTIS_T_EXT2_IF] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Timer counter
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            timer_cfg_r <= `PTIS_RST_TCFG;
            timer_count_low_r <= 8'h00;
            timer_count_high_r <= 8'h00;
        end else begin
            if (hit(`PTIS_ADDR_TIMER_CFG)) begin
                timer_cfg_r <= wbyte(timer_cfg_r);
            end
            // Count on tick, writes override
            if (timer_cfg_r[`PTIS_C_RUN] && timer_tick_in) begin
                timer_count_low_r <= timer_count_low_r + 8'h01;
                if (tmr_wrap_low && !timer_cfg_r[`PTIS_C_MODE8]) begin
                    timer_count_high_r <= timer_count_high_r + 8'h01;
                end
            end
            if (hit(`PTIS_ADDR_TIMER_LOW)) begin
                timer_count_low_r <= wbyte(timer_count_low_r);
            end
            if (hit(`PTIS_ADDR_TIMER_HIGH)) begin
                timer_count_high_r <= wbyte(timer_count_high_r);
            end
        end
    end

    // ****************************************
    // Sticky status and mask
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_status_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (hit(`PTIS_ADDR_IRQ_MASK)) begin
                // Lane zero carries the mask bits; no lane keeps the old mask
                irq_mask_r <= avs_byteenable_in[0] ? avs_writedata_in[`PTIS_EV_BITS-1:0] : irq_mask_r;
            end
            // Write one clears, new events win
            irq_status_r <= (irq_status_r & ~(hit(`PTIS_ADDR_IRQ_STATUS) && avs_byteenable_in[0]
                            ? avs_writedata_in[`PTIS_EV_BITS-1:0] : '0))
                          | {wake_evt, port_change, tmr_ovf, ext_edge};
        end
    end

    // ****************************************
    // Request and wake outputs
    // ****************************************
    logic [4:0] req; // Flag and enable per source
    logic [4:0] prio; // Priority per source
    assign req = {ctrl_primary_r[`PTIS_P_PORT_IF] & ctrl_primary_r[`PTIS_P_PORT_IE],
                  ctrl_primary_r[`PTIS_P_TMR_IF] & ctrl_primary_r[`PTIS_P_TMR_IE],
                  ext_flag & ext_en};
    assign prio = {ctrl_second_r[`PTIS_S_PORT_IP], ctrl_second_r[`PTIS_S_TMR_IP],
                   ctrl_third_r[`PTIS_T_EXT2_IP], ctrl_third_r[`PTIS_T_EXT1_IP],
                   1'b1};

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_high_out <= 1'b0;
            irq_low_out <= 1'b0;
            wake_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            // Vector request gated by global enable
            irq_high_out <= ctrl_primary_r[`PTIS_P_GIE] & |(req & prio);
            irq_low_out <= ctrl_primary_r[`PTIS_P_GIE] & |(req & ~prio);
            wake_out <= wake_evt;
            irq_out <= |(irq_status_r & irq_mask_r);
        end
    end

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bus_state_r <= PTIS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            case (bus_state_r)
                PTIS_IDLE: begin
                    // Request seen, release wait next
                    if (avs_read_in || avs_write_in) begin
                        bus_state_r <= PTIS_ACK;
                        avs_waitrequest_out <= 1'b0;
                        case (avs_address_in)
                            `PTIS_ADDR_CTRL_PRIMARY: avs_readdata_out <= {24'h0, ctrl_primary_r};
                            `PTIS_ADDR_CTRL_SECOND: avs_readdata_out <= {24'h0, ctrl_second_r};
                            `PTIS_ADDR_CTRL_THIRD: avs_readdata_out <= {24'h0, ctrl_third_r};
                            `PTIS_ADDR_TIMER_LOW: avs_readdata_out <= {24'h0, timer_count_low_r};
                            `PTIS_ADDR_TIMER_HIGH: avs_readdata_out <= {24'h0, timer_count_high_r};
                            `PTIS_ADDR_TIMER_CFG: avs_readdata_out <= {24'h0, timer_cfg_r};
                            `PTIS_ADDR_IRQ_STATUS: avs_readdata_out <= {26'h0, irq_status_r};
                            `PTIS_ADDR_IRQ_MASK: avs_readdata_out <= {26'h0, irq_mask_r};
                            default: avs_readdata_out <= 32'h0000_0000;
                        endcase
                    end
                end
                PTIS_ACK: begin
                    // Transfer completes this edge
                    bus_state_r <= PTIS_DONE;
                    avs_waitrequest_out <= 1'b1;
                end
                PTIS_DONE: begin
                    // One idle cycle lets master drop request
                    bus_state_r <= PTIS_IDLE;
                end
                default: begin
                    bus_state_r <= PTIS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: ptis_irq_src_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Bus and request output checks
// ****************************************
module ptis_irq_src_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic sleep_in,
    input wire logic irq_high_out,
    input wire logic irq_low_out,
    input wire logic wake_out,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_rst;
        $fell(rst_in) |-> avs_waitrequest_out && !irq_out && !irq_high_out && !irq_low_out && !wake_out;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_wait_one;
        $fell(avs_waitrequest_out) |=> avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_wait_cause;
        !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_answer;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_upper_zero;
        avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
    property p_unmapped;
        avs_read_in && !avs_waitrequest_out && avs_address_in[3] |-> avs_readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_wake_pulse;
        wake_out |=> !wake_out;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
    property p_wake_sleep;
        wake_out |-> $past(sleep_in);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
    property p_irq_fall;
        $fell(irq_out) |-> $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    property p_high_fall;
        $fell(irq_high_out) |-> $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3);
    endproperty
    a_high_fall: assert property (p_high_fall) else $error("high request dropped");
    property p_low_fall;
        $fell(irq_low_out) |-> $past(avs_write_in) || $past(avs_write_in, 2) || $past(avs_write_in, 3);
    endproperty
    a_low_fall: assert property (p_low_fall) else $error("low request dropped");
endmodule
bind ptis_irq_src ptis_irq_src_monitor i_ptis_irq_src_monitor (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .sleep_in(sleep_in),
    .irq_high_out(irq_high_out), .irq_low_out(irq_low_out), .wake_out(wake_out), .irq_out(irq_out));
`default_nettype wire

// File: ptis_irq_src_test.sv
`timescale 1ns/10ps
`default_nettype none
module ptis_irq_src_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic sleep = 1'b0;
    logic tick = 1'b0;
    logic [31:0] rdata;
    logic wreq, irq_hi, irq_lo, wake, irq;
    logic [2:0] ext;
    logic [3:0] port;
    logic [7:0] q;
    int error_cnt = 0;
    int samples_checked = 0;
    int wk = 0;
    localparam logic [7:0] RV [0:8] = '{8'h00, 8'h75, 8'hC0, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    // Primary, third, second, expected high and low request
    localparam logic [31:0] TAB [0:12] = '{32'h92000002, 32'h80490002, 32'h80090001, 32'h80410000,
        32'h80920002, 32'h80120001, 32'hA4000402, 32'hA4000001, 32'h84000400, 32'h89000102,
        32'h89000001, 32'h81000100, 32'h12000000};
    always #5 clk = ~clk;
    // Count wake pulses
    always @(posedge clk) if (wake === 1'b1) wk <= wk + 1;
    ptis_pin_src i_ptis_pin_src (.clk_in(clk), .ext_out(ext), .port_out(port));
    ptis_irq_src i_ptis_irq_src (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd_en),
        .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .ext_irq_line_zero_in(ext[0]), .ext_irq_line_one_in(ext[1]),
        .ext_irq_line_two_in(ext[2]), .port_b_pins_in(port), .sleep_in(sleep), .timer_tick_in(tick),
        .irq_high_out(irq_hi), .irq_low_out(irq_lo), .wake_out(wake), .irq_out(irq));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr_en <= w;
        rd_en <= !w;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata[7:0];
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic tk;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 9; k++) rc(k[3:0], RV[k], "reset value");
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            wr(4'h1, p ? 8'h70 : 8'h00);
            for (int i = 0; i < 3; i++) begin
                i_ptis_pin_src.drive(i, p[0]);
                wr(4'h0, 8'h00);
                wr(4'h2, 8'h00);
                wr(4'h6, 8'h3F);
                i_ptis_pin_src.drive(i, !p[0]);
                rc(4'h6, 8'h00, "wrong edge");
                i_ptis_pin_src.drive(i, p[0]);
                rc(4'h6, 8'h01 << i, "edge status");
                rc(i ? 4'h2 : 4'h0, i ? 8'h01 << (i - 1) : 8'h02, "edge flag");
            end
        end
        $display("test edges done");
        for (int k = 0; k < 13; k++) begin
            wr(4'h1, TAB[k][15:8]);
            wr(4'h2, TAB[k][23:16]);
            wr(4'h0, TAB[k][31:24]);
            repeat (3) @(posedge clk);
            chk("high req", {7'h0, TAB[k][1]}, {7'h0, irq_hi});
            chk("low req", {7'h0, TAB[k][0]}, {7'h0, irq_lo});
            wr(4'h0, 8'h00);
            wr(4'h2, 8'h00);
        end
        $display("test requests done");
        wr(4'h6, 8'h3F);
        wr(4'h5, 8'hC0);
        wr(4'h3, 8'hFE);
        tk;
        rc(4'h0, 8'h00, "no overflow");
        tk;
        rc(4'h3, 8'h00, "count low");
        rc(4'h0, 8'h04, "8-bit overflow");
        rc(4'h6, 8'h08, "timer status");
        wr(4'h5, 8'h80);
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'h3, 8'hFF);
        tk;
        rc(4'h4, 8'h01, "carry");
        rc(4'h0, 8'h00, "no 16-bit overflow");
        wr(4'h4, 8'hFF);
        wr(4'h3, 8'hFF);
        tk;
        rc(4'h4, 8'h00, "count high");
        rc(4'h0, 8'h04, "16-bit overflow");
        wr(4'h5, 8'h40);
        $display("test timer done");
        wr(4'h6, 8'h3F);
        wr(4'h7, 8'h10);
        for (int j = 0; j < 4; j++) begin
            wr(4'h0, 8'h00);
            i_ptis_pin_src.drive(3 + j, 1'b1);
            rc(4'h0, 8'h01, "port flag");
            chk("irq level", 8'h01, {7'h0, irq});
            wr(4'h6, 8'h10);
            repeat (3) @(posedge clk);
            chk("irq cleared", 8'h00, {7'h0, irq});
        end
        wr(4'h7, 8'h00);
        wr(4'h9, 8'hFF);
        rc(4'h7, 8'h00, "unmapped write");
        i_ptis_pin_src.drive(3, 1'b0);
        rc(4'h6, 8'h10, "port status");
        chk("irq masked", 8'h00, {7'h0, irq});
        $display("test port done");
        wr(4'h6, 8'h3F);
        wr(4'h1, 8'h70);
        wr(4'h2, 8'h08);
        i_ptis_pin_src.drive(1, 1'b0);
        i_ptis_pin_src.drive(2, 1'b0);
        sleep <= 1'b1;
        i_ptis_pin_src.drive(2, 1'b1);
        chk("wake count", 8'h00, wk[7:0]);
        i_ptis_pin_src.drive(1, 1'b1);
        chk("wake count", 8'h01, wk[7:0]);
        sleep <= 1'b0;
        rc(4'h6, 8'h26, "wake status");
        $display("test wake done");
        summarize;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize;
    end
endmodule
`default_nettype wire

// File: ptis_map.svh
`ifndef PTIS_MAP_SVH
`define PTIS_MAP_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define PTIS_ADDR_CTRL_PRIMARY 4'h0
`define PTIS_ADDR_CTRL_SECOND 4'h1
`define PTIS_ADDR_CTRL_THIRD 4'h2
`define PTIS_ADDR_TIMER_LOW 4'h3
`define PTIS_ADDR_TIMER_HIGH 4'h4
`define PTIS_ADDR_TIMER_CFG 4'h5
`define PTIS_ADDR_IRQ_STATUS 4'h6
`define PTIS_ADDR_IRQ_MASK 4'h7

// ****************************************
// Primary control register fields
// ****************************************
`define PTIS_P_GIE 7
`define PTIS_P_TMR_IE 5
`define PTIS_P_EXT0_IE 4
`define PTIS_P_PORT_IE 3
`define PTIS_P_TMR_IF 2
`define PTIS_P_EXT0_IF 1
`define PTIS_P_PORT_IF 0

// ****************************************
// Second control register fields
// ****************************************
`define PTIS_S_EDGE0 6
`define PTIS_S_EDGE1 5
`define PTIS_S_EDGE2 4
`define PTIS_S_TMR_IP 2
`define PTIS_S_PORT_IP 0

// ****************************************
// Third control register fields
// ****************************************
`define PTIS_T_EXT2_IP 7
`define PTIS_T_EXT1_IP 6
`define PTIS_T_EXT2_IE 4
`define PTIS_T_EXT1_IE 3
`define PTIS_T_EXT2_IF 1
`define PTIS_T_EXT1_IF 0

// ****************************************
// Timer configuration fields
// ****************************************
`define PTIS_C_RUN 7
`define PTIS_C_MODE8 6

// ****************************************
// Reset values
// ****************************************
`define PTIS_RST_PRIMARY 8'h00
`define PTIS_RST_SECOND 8'h75
`define PTIS_RST_THIRD 8'hC0
`define PTIS_RST_TCFG 8'h40
`define PTIS_RST_MASK 8'h00

// ****************************************
// Status register event bit positions
// ****************************************
`define PTIS_EV_EXT0 0
`define PTIS_EV_EXT1 1
`define PTIS_EV_EXT2 2
`define PTIS_EV_TMR 3
`define PTIS_EV_PORT 4
`define PTIS_EV_WAKE 5
`define PTIS_EV_BITS 6

`endif

// File: ptis_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// External pin sources
// ****************************************
module ptis_pin_src (
    // Clock
    input wire logic clk_in,
    // Pin levels
    output logic [2:0] ext_out,
    output logic [3:0] port_out
);
    // Pins start low
    initial begin
        ext_out = 3'h0;
        port_out = 4'h0;
    end
    // Move one pin, then hold it until seen
    task automatic drive(input int i, input logic v);
        @(posedge clk_in);
        if (i < 3) ext_out[i] <= v;
        else port_out[i - 3] <= v;
        repeat (6) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: ptis_pkg.sv
`default_nettype none
// ****************************************
// Shared types
// ****************************************
package ptis_pkg;
    // Bus slave states, Gray coded
    typedef enum logic [1:0] {
        PTIS_IDLE = 2'b00,
        PTIS_ACK = 2'b01,
        PTIS_DONE = 2'b11
    } ptis_bus_state_t;
endpackage
`default_nettype wire
